// [qaw_answer_calc.v]
`timescale 1ns/10ps
`default_nettype none

// expected answer byte for one answer index
module qaw_answer_calc (
    input  wire [3:0] i_question,
    input  wire [1:0] i_idx,
    input  wire [1:0] i_option,
    output wire [7:0] o_expected
);

    wire [3:0] mix_a;
    wire [3:0] mix_b;

    assign mix_a = i_question ^ {i_idx, i_idx};
    assign mix_b = {i_question[0], i_question[3:1]} ^ {2'h0, i_option};
    assign o_expected = i_idx[0] ? {~mix_b, mix_a} : {mix_a, mix_b};

endmodule

`default_nettype wire

// [qaw_defines.vh]
`ifndef QAW_DEFINES_VH
`define QAW_DEFINES_VH

// register indexes, byte address is four times the index
`define QAW_IDX_SETUP_A        8'h13
`define QAW_IDX_SETUP_B        8'h14
`define QAW_IDX_KICK           8'h15
`define QAW_IDX_CHAL_SETUP     8'h2D
`define QAW_IDX_RESPONSE       8'h2E
`define QAW_IDX_CHAL_VALUE     8'h2F
`define QAW_IDX_IRQ_STATUS     8'h30
`define QAW_IDX_IRQ_MASK       8'h31

// reset values
`define QAW_SETUP_A_RST        8'h04
`define QAW_SETUP_B_RST        8'h0F
`define QAW_CHAL_SETUP_RST     8'h09
`define QAW_IRQ_MASK_RST       3'h0
`define QAW_QUESTION_RST       4'h9

// watchdog_setup_a fields
`define QAW_STYLE_MSB          7
`define QAW_STYLE_LSB          6
`define QAW_WSIZE_MSB          2
`define QAW_WSIZE_LSB          0

// watchdog_setup_b fields
`define QAW_LIMIT_MSB          3
`define QAW_LIMIT_LSB          0

// challenge_setup fields
`define QAW_OPT_MSB            7
`define QAW_OPT_LSB            6
`define QAW_POLY_MSB           5
`define QAW_POLY_LSB           4
`define QAW_SEED_MSB           3
`define QAW_SEED_LSB           0

// challenge_value read layout
`define QAW_RD_QUEST_LSB       0
`define QAW_RD_FAIL_LSB        8
`define QAW_RD_AERR_BIT        12
`define QAW_RD_WERR_BIT        13
`define QAW_RD_CNT_LSB         14

// interrupt status bits
`define QAW_IRQ_WERR_BIT       0
`define QAW_IRQ_AERR_BIT       1
`define QAW_IRQ_ACT_BIT        2

// command and style codes
`define QAW_KICK_CODE          8'hFF
`define QAW_STYLE_MULTI        2'h0

// timing: base window unit in ms and clock rate in MHz
`define QAW_WIN_UNIT_MS        64
`define QAW_CLK_MHZ            125

`endif

// [qaw_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module qaw_host_model #(
    parameter int WH = 128
) (
    input  wire logic        i_clock,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_wait,
    output var  logic [9:0]  o_addr,
    output var  logic        o_rd,
    output var  logic        o_wr,
    output var  logic [31:0] o_wdata,
    output var  logic [3:0]  o_be
);
    int          tick = 0;
    int          base = 0;
    logic [31:0] dmy;
    logic [1:0]  opt = 2'h0;
    initial begin
        o_addr = 10'h000;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 32'h0;
        o_be = 4'hF;
    end
    always @(posedge i_clock) tick <= tick + 1;
    // bus cycle held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clock);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= w;
        o_rd <= ~w;
        do @(posedge i_clock); while (i_wait !== 1'b0);
        q = i_rdata;
        o_wr <= 1'b0;
        o_rd <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, dmy);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    // start code to the kick register
    task automatic kick();
        wr(10'h054, 32'hFF);
    endtask
    // own timer marks the cycle start
    task automatic mark();
        base = tick;
    endtask
    task automatic upto(input int n);
        wait (tick - base >= n);
    endtask
    task automatic shift(input int n);
        base = base + n;
    endtask
    // answer bytes worked out from the question
    function automatic logic [7:0] ans(input logic [3:0] q, input logic [1:0] k);
        logic [3:0] a;
        logic [3:0] b;
        a = q ^ {k, k};
        b = {q[0], q[3:1]} ^ {2'h0, opt};
        return k[0] ? {~b, a} : {a, b};
    endfunction
    // answers go out from index hi down to lo, bad ones inverted
    task automatic answers(input logic [3:0] q, input int hi, input int lo,
                           input logic [3:0] bad);
        for (int k = hi; k >= lo; k--) begin
            wr(10'h0B8, {24'h0, ans(q, k[1:0]) ^ {8{bad[k]}}});
        end
    endtask
endmodule
`default_nettype wire

// [qaw_watchdog.v]
// Operation
// - multi-answer evaluation runs only while the style select field is zero.
// - four correct answers in window one end the cycle, keep the question, raise only the watchdog error and count a failure.
// - three correct then one wrong in window two end the cycle, count a failure, keep the question and raise both flags.
// - three wrong answers in window one with fewer than four in all end the cycle at the end of window two with both flags set.
// - three wrong then any one in window two end the cycle at that answer, count a failure, keep the question, raise both flags.
// - four answers in window one with any wrong end the cycle, count a failure, keep the question, raise both flags.
// - when the failure count reaches the programmed limit the watchdog action is taken.
// - the window size is programmable, one setting giving 1024 ms for both response windows together.
// - after reset answer option and polynomial are zero and the seed is nine.
// - writing FF to the kick register starts the watchdog when it is idle and the style select field is zero.
// - the current question is readable in the challenge value register.
// - the challenge value register also shows the failure count and the error flags.
// - three correct in window one and one correct in window two end the cycle, decrement a nonzero count, renew the question, clear both flags.
// - fewer than four answers with none in window two end the cycle at the end of window two, count a failure, set the watchdog error.
`timescale 1ns/10ps
`default_nettype none
`include "qaw_defines.vh"

module qaw_watchdog #(
    parameter [31:0] WIN_UNIT_CYCLES = `QAW_WIN_UNIT_MS * 1000 * `QAW_CLK_MHZ
) (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire [9:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    output reg         o_irq,
    output reg         o_wd_action
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WIN1 = 2'h1;
    localparam [1:0] ST_WIN2 = 2'h2;

    // register file
    reg  [7:0]  setup_a_q;
    reg  [7:0]  setup_b_q;
    reg  [7:0]  chal_setup_q;
    reg  [2:0]  irq_status_q;
    reg  [2:0]  irq_mask_q;

    // evaluation state
    reg  [1:0]  state_q;
    reg  [31:0] timer_q;
    reg  [3:0]  question_q;
    reg  [2:0]  answer_count_q;
    reg  [2:0]  win1_count_q;
    reg         any_bad_q;
    reg  [3:0]  fail_count_q;
    reg         answer_error_flag_q;
    reg         watchdog_error_flag_q;

    // bus decode
    wire        bus_req;
    wire        bus_take;
    wire        addr_ok;
    wire [7:0]  reg_idx;
    wire        wr_lane0;
    wire [7:0]  wr_byte;
    wire        wr_setup_a;
    wire        wr_setup_b;
    wire        wr_kick;
    wire        wr_chal_setup;
    wire        wr_response;
    wire        wr_irq_status;
    wire        wr_irq_mask;

    assign bus_req  = i_avs_read | i_avs_write;
    assign bus_take = bus_req & ~o_avs_waitrequest;
    assign addr_ok  = (i_avs_address[1:0] == 2'h0);
    assign reg_idx  = i_avs_address[9:2];
    assign wr_lane0 = bus_take & i_avs_write & i_avs_byteenable[0] & addr_ok;
    assign wr_byte  = i_avs_writedata[7:0];

    assign wr_setup_a    = wr_lane0 & (reg_idx == `QAW_IDX_SETUP_A);
    assign wr_setup_b    = wr_lane0 & (reg_idx == `QAW_IDX_SETUP_B);
    assign wr_kick       = wr_lane0 & (reg_idx == `QAW_IDX_KICK);
    assign wr_chal_setup = wr_lane0 & (reg_idx == `QAW_IDX_CHAL_SETUP);
    assign wr_response   = wr_lane0 & (reg_idx == `QAW_IDX_RESPONSE);
    assign wr_irq_status = wr_lane0 & (reg_idx == `QAW_IDX_IRQ_STATUS);
    assign wr_irq_mask   = wr_lane0 & (reg_idx == `QAW_IDX_IRQ_MASK);

    // configuration fields
    wire [1:0]  style_sel;
    wire [2:0]  win_size;
    wire [3:0]  fail_limit;
    wire [1:0]  ans_option;
    wire [1:0]  poly_sel;
    wire [3:0]  seed;

    assign style_sel  = setup_a_q[`QAW_STYLE_MSB:`QAW_STYLE_LSB];
    assign win_size   = setup_a_q[`QAW_WSIZE_MSB:`QAW_WSIZE_LSB];
    assign fail_limit = setup_b_q[`QAW_LIMIT_MSB:`QAW_LIMIT_LSB];
    assign ans_option = chal_setup_q[`QAW_OPT_MSB:`QAW_OPT_LSB];
    assign poly_sel   = chal_setup_q[`QAW_POLY_MSB:`QAW_POLY_LSB];
    assign seed       = chal_setup_q[`QAW_SEED_MSB:`QAW_SEED_LSB];

    wire [31:0] win_total;
    wire [31:0] win_half;

    assign win_total = WIN_UNIT_CYCLES << win_size;
    assign win_half  = {1'b0, win_total[31:1]};

    // answer checking
    wire [1:0]  ans_idx;
    wire [7:0]  expected;
    wire        ans_correct;

    assign ans_idx     = 2'h3 - answer_count_q[1:0];
    assign ans_correct = (wr_byte == expected);

    qaw_answer_calc u_answer_calc (
        .i_question (question_q),
        .i_idx      (ans_idx),
        .i_option   (ans_option),
        .o_expected (expected)
    );

    // question renewal
    reg  [3:0]  question_next;

    always @* begin
        case (poly_sel)
            2'h0: question_next = {question_q[2:0], question_q[3] ^ question_q[2]};
            2'h1: question_next = {question_q[2:0], question_q[3] ^ question_q[0]};
            2'h2: question_next = {question_q[0], question_q[3] ^ question_q[0], question_q[2:1]};
            default: question_next = {question_q[2:0], ~question_q[3]};
        endcase
    end

    // cycle end decisions
    wire        running;
    wire        win1_end;
    wire        win2_end;
    wire        take_answer;
    wire        fourth;
    wire        bad_total;
    wire        good_seq;
    wire        end_by_answer;
    wire        end_by_time;
    wire        cycle_end;
    wire        fail_event;
    wire        hit_limit;

    assign running  = (state_q != ST_IDLE) & (style_sel == `QAW_STYLE_MULTI);
    assign win1_end = running & (state_q == ST_WIN1) & (timer_q >= win_half - 32'h1);
    assign win2_end = running & (state_q == ST_WIN2) & (timer_q >= win_half - 32'h1);

    assign take_answer = running & wr_response;
    assign fourth      = take_answer & (answer_count_q == 3'h3);
    assign bad_total   = any_bad_q | (take_answer & ~ans_correct);

    assign good_seq = fourth & (state_q == ST_WIN2) & (win1_count_q == 3'h3)
                      & ~any_bad_q & ans_correct;

    assign end_by_answer = fourth;
    assign end_by_time   = win2_end & ~fourth;
    assign cycle_end     = end_by_answer | end_by_time;
    assign fail_event    = cycle_end & ~good_seq;
    assign hit_limit     = fail_event & (fail_count_q + 4'h1 >= fail_limit);

    // bus handshake, answer one cycle after the request is seen
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else if (bus_req & o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    // read data prepared while waitrequest is high
    reg  [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0;
        if (addr_ok) begin
            case (reg_idx)
                `QAW_IDX_SETUP_A:    rd_mux[7:0] = setup_a_q;
                `QAW_IDX_SETUP_B:    rd_mux[7:0] = setup_b_q;
                `QAW_IDX_CHAL_SETUP: rd_mux[7:0] = chal_setup_q;
                `QAW_IDX_CHAL_VALUE: begin
                    rd_mux[`QAW_RD_QUEST_LSB+3:`QAW_RD_QUEST_LSB] = question_q;
                    rd_mux[`QAW_RD_FAIL_LSB+3:`QAW_RD_FAIL_LSB] = fail_count_q;
                    rd_mux[`QAW_RD_AERR_BIT] = answer_error_flag_q;
                    rd_mux[`QAW_RD_WERR_BIT] = watchdog_error_flag_q;
                    rd_mux[`QAW_RD_CNT_LSB+1:`QAW_RD_CNT_LSB] = answer_count_q[1:0];
                end
                `QAW_IDX_IRQ_STATUS: rd_mux[2:0] = irq_status_q;
                `QAW_IDX_IRQ_MASK:   rd_mux[2:0] = irq_mask_q;
                default:             rd_mux = 32'h0;
            endcase
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0;
        end else if (i_avs_read & o_avs_waitrequest) begin
            o_avs_readdata <= rd_mux;
        end
    end

    // configuration registers
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            setup_a_q    <= `QAW_SETUP_A_RST;
            setup_b_q    <= `QAW_SETUP_B_RST;
            chal_setup_q <= `QAW_CHAL_SETUP_RST;
            irq_mask_q   <= `QAW_IRQ_MASK_RST;
        end else begin
            if (wr_setup_a) begin
                setup_a_q <= wr_byte;
            end
            if (wr_setup_b) begin
                setup_b_q <= wr_byte;
            end
            if (wr_chal_setup) begin
                chal_setup_q <= wr_byte;
            end
            if (wr_irq_mask) begin
                irq_mask_q <= wr_byte[2:0];
            end
        end
    end

    // cycle state machine
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q        <= ST_IDLE;
            timer_q        <= 32'h0;
            answer_count_q <= 3'h0;
            win1_count_q   <= 3'h0;
            any_bad_q      <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_kick & (wr_byte == `QAW_KICK_CODE)
                        & (style_sel == `QAW_STYLE_MULTI)) begin
                        state_q        <= ST_WIN1;
                        timer_q        <= 32'h0;
                        answer_count_q <= 3'h0;
                        win1_count_q   <= 3'h0;
                        any_bad_q      <= 1'b0;
                    end
                end
                ST_WIN1, ST_WIN2: begin
                    if (!running) begin
                        state_q <= ST_IDLE;
                    end else if (cycle_end) begin
                        state_q        <= ST_WIN1;
                        timer_q        <= 32'h0;
                        answer_count_q <= 3'h0;
                        win1_count_q   <= 3'h0;
                        any_bad_q      <= 1'b0;
                    end else begin
                        if (win1_end) begin
                            state_q <= ST_WIN2;
                            timer_q <= 32'h0;
                        end else begin
                            timer_q <= timer_q + 32'h1;
                        end
                        if (take_answer) begin
                            answer_count_q <= answer_count_q + 3'h1;
                            any_bad_q      <= bad_total;
                            if (state_q == ST_WIN1) begin
                                win1_count_q <= win1_count_q + 3'h1;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // question, failure counter and flags
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            question_q            <= `QAW_QUESTION_RST;
            fail_count_q          <= 4'h0;
            answer_error_flag_q   <= 1'b0;
            watchdog_error_flag_q <= 1'b0;
        end else begin
            if ((state_q == ST_IDLE) & wr_kick & (wr_byte == `QAW_KICK_CODE)) begin
                question_q <= seed;
            end else if (running & cycle_end) begin
                if (good_seq) begin
                    question_q            <= question_next;
                    answer_error_flag_q   <= 1'b0;
                    watchdog_error_flag_q <= 1'b0;
                    if (fail_count_q != 4'h0) begin
                        fail_count_q <= fail_count_q - 4'h1;
                    end
                end else begin
                    answer_error_flag_q   <= bad_total;
                    watchdog_error_flag_q <= 1'b1;
                    if (hit_limit) begin
                        fail_count_q <= 4'h0;
                    end else begin
                        fail_count_q <= fail_count_q + 4'h1;
                    end
                end
            end
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_wd_action <= 1'b0;
        end else begin
            o_wd_action <= running & hit_limit;
        end
    end

    // interrupt status, set wins over write-one clear
    wire [2:0]  irq_set;
    wire [2:0]  irq_clr;
    wire [2:0]  irq_status_d;

    assign irq_set[`QAW_IRQ_WERR_BIT] = running & fail_event;
    assign irq_set[`QAW_IRQ_AERR_BIT] = running & fail_event & bad_total;
    assign irq_set[`QAW_IRQ_ACT_BIT]  = running & hit_limit;
    assign irq_clr      = wr_irq_status ? wr_byte[2:0] : 3'h0;
    assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            irq_status_q <= 3'h0;
            o_irq        <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            o_irq        <= |(irq_status_d & irq_mask_q);
        end
    end

endmodule

`default_nettype wire

// [qaw_watchdog_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module qaw_watchdog_chk #(
    parameter [31:0] WIN_UNIT_CYCLES = 32'h10
) (
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic [9:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_irq,
    input wire logic        o_wd_action
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire logic req = i_avs_read | i_avs_write;
    wire logic rdone = i_avs_read & ~o_avs_waitrequest;
    a_wait_after_req: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_has_cause: assert property ($fell(o_avs_waitrequest) |-> req)
        else $error("answer without request");
    a_data_held: assert property ($changed(o_avs_readdata) |-> rdone)
        else $error("read data moved outside a read");
    a_unmapped_zero: assert property (rdone && (i_avs_address[1:0] != 2'h0
        || i_avs_address > 10'h0C7) |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_wo_zero: assert property (rdone && (i_avs_address == 10'h054
        || i_avs_address == 10'h0B8) |-> o_avs_readdata == 32'h0)
        else $error("write-only read not zero");
    a_action_pulse: assert property (o_wd_action |=> !o_wd_action)
        else $error("action longer than one cycle");
    a_kick_quiet: assert property (i_avs_write && !o_avs_waitrequest
        && i_avs_address == 10'h054 |=> !o_wd_action [*8])
        else $error("action right after start");
    c_action: cover property (o_wd_action);
    c_irq: cover property ($rose(o_irq));
    c_chal_read: cover property (rdone && i_avs_address == 10'h0BC);
endmodule
`default_nettype wire

// [tb_qa_watchdog_multi_answer.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_qa_watchdog_multi_answer;
    localparam int WH = (16 << 4) / 2;
    logic        i_clock = 1'b0;
    logic        i_rst_n = 1'b0;
    wire  [9:0]  addr;
    wire         rd;
    wire         wr;
    wire  [31:0] wdata;
    wire  [3:0]  be;
    wire  [31:0] rdata;
    wire         wt;
    wire         irq;
    wire         act;
    logic [31:0] rdat;
    logic [3:0]  q;
    int          n_fail = 0;
    int          checks = 0;
    int          acts = 0;
    qaw_watchdog #(.WIN_UNIT_CYCLES(32'd16)) qaw_watchdog_inst (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wt), .o_irq(irq), .o_wd_action(act));
    qaw_host_model #(.WH(WH)) qaw_host_model_inst (
        .i_clock(i_clock), .i_rdata(rdata), .i_wait(wt), .o_addr(addr),
        .o_rd(rd), .o_wr(wr), .o_wdata(wdata), .o_be(be));
    initial forever #4 i_clock = ~i_clock;
    always @(posedge i_clock) if (act === 1'b1) acts <= acts + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rq(input logic [9:0] a, input logic [31:0] e);
        qaw_host_model_inst.rd(a, rdat);
        check(rdat, e);
    endtask
    task automatic w(input logic [9:0] a, input logic [7:0] d);
        qaw_host_model_inst.wr(a, {24'h0, d});
    endtask
    task automatic an(input int hi, input int lo, input logic [3:0] bad);
        qaw_host_model_inst.answers(q, hi, lo, bad);
    endtask
    task automatic up(input int n);
        qaw_host_model_inst.upto(n);
    endtask
    function automatic logic [31:0] cv(logic [3:0] c, logic ae, logic we);
        return {18'h0, we, ae, c, 4'h0, q};
    endfunction
    initial begin
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        q = 4'h9;
        rq(10'h04C, 32'h04);
        rq(10'h050, 32'h0F);
        rq(10'h0B4, 32'h09);
        rq(10'h0BC, cv(4'h0, 1'b0, 1'b0));
        rq(10'h3FC, 32'h0);
        rq(10'h054, 32'h0);
        rq(10'h0B8, 32'h0);
        qaw_host_model_inst.o_be <= 4'h0;
        w(10'h050, 8'h03);
        qaw_host_model_inst.o_be <= 4'hF;
        rq(10'h050, 32'h0F);
        w(10'h0C4, 8'h07);
        rq(10'h0C4, 32'h07);
        w(10'h04C, 8'h44);
        qaw_host_model_inst.kick();
        an(3, 0, 4'h0);
        rq(10'h0BC, cv(4'h0, 1'b0, 1'b0));
        w(10'h04C, 8'h04);
        $display("test setup done");
        qaw_host_model_inst.kick();
        an(3, 0, 4'h0);
        qaw_host_model_inst.mark();
        rq(10'h0BC, cv(4'h1, 1'b0, 1'b1));
        rq(10'h0C0, 32'h1);
        check({31'h0, irq}, 32'h1);
        w(10'h0C0, 8'h07);
        @(posedge i_clock);
        check({31'h0, irq}, 32'h0);
        an(3, 1, 4'h0);
        up(WH + 4);
        an(0, 0, 4'h0);
        qaw_host_model_inst.mark();
        qaw_host_model_inst.rd(10'h0BC, rdat);
        check(rdat & 32'hFFF0, 32'h0);
        check({31'h0, rdat[3:0] == q}, 32'h0);
        q = rdat[3:0];
        an(3, 1, 4'h0);
        up(WH + 4);
        an(0, 0, 4'h1);
        qaw_host_model_inst.mark();
        rq(10'h0BC, cv(4'h1, 1'b1, 1'b1));
        an(3, 1, 4'hE);
        up(WH + 4);
        an(0, 0, 4'h0);
        qaw_host_model_inst.mark();
        rq(10'h0BC, cv(4'h2, 1'b1, 1'b1));
        an(3, 0, 4'h2);
        qaw_host_model_inst.mark();
        rq(10'h0BC, cv(4'h3, 1'b1, 1'b1));
        $display("test answer cycles done");
        an(3, 1, 4'hE);
        up(2 * WH - 10);
        rq(10'h0BC, cv(4'h3, 1'b1, 1'b1) | 32'hC000);
        up(2 * WH + 10);
        qaw_host_model_inst.shift(2 * WH);
        rq(10'h0BC, cv(4'h4, 1'b1, 1'b1));
        w(10'h0B4, 8'h49);
        qaw_host_model_inst.opt = 2'h1;
        rq(10'h0B4, 32'h49);
        an(3, 1, 4'h0);
        up(2 * WH + 10);
        qaw_host_model_inst.shift(2 * WH);
        rq(10'h0BC, cv(4'h5, 1'b0, 1'b1));
        $display("test window ends done");
        w(10'h050, 8'h07);
        w(10'h0C4, 8'h04);
        w(10'h0C0, 8'h07);
        an(3, 0, 4'h1);
        rq(10'h0BC, cv(4'h6, 1'b1, 1'b1));
        check({31'h0, irq}, 32'h0);
        check(acts, 32'h0);
        an(3, 0, 4'h1);
        rq(10'h0BC, cv(4'h0, 1'b1, 1'b1));
        check(acts, 32'h1);
        rq(10'h0C0, 32'h7);
        check({31'h0, irq}, 32'h1);
        $display("test limit done");
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        end_sim();
    end
endmodule
bind qaw_watchdog qaw_watchdog_chk #(.WIN_UNIT_CYCLES(WIN_UNIT_CYCLES)) qaw_watchdog_chk_inst (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_irq(o_irq), .o_wd_action(o_wd_action));
`default_nettype wire
